// *** shared/fsc_map.svh ***
// Register indices, field positions, reset values and timing of the forced-stop controller
`ifndef FSC_MAP_SVH
`define FSC_MAP_SVH
// Register indices; byte address is four times the index
`define FSC_IDX_METHOD 16'h200a
`define FSC_IDX_DECEL 16'h230a
`define FSC_IDX_ESTOP 16'h2406
`define FSC_IDX_CTRL 16'h2500
`define FSC_IDX_STAT 16'h2501
`define FSC_IDX_IRQ_STAT 16'h2502
`define FSC_IDX_IRQ_CLR 16'h2503
`define FSC_IDX_IRQ_EN 16'h2504
// Stop method field of the function select register
`define FSC_METHOD_LSB 4
`define FSC_METHOD_MAX 3'h4
`define FSC_METHOD_RST 16'h0010
// Control register fields
`define FSC_CTRL_ALLOC_LSB 0
`define FSC_CTRL_COAST_BIT 4
`define FSC_CTRL_G2_LSB 5
`define FSC_CTRL_RST 16'h0000
// Setting limits and reset values
`define FSC_DECEL_RST 16'h0000
`define FSC_DECEL_MAX 16'h2710
`define FSC_ESTOP_RST 16'h0320
`define FSC_ESTOP_MAX 16'h0320
// Timing: clock period and one millisecond, in picoseconds
`define FSC_CLK_PS 5000
`define FSC_MS_PS 1000000000
`endif

// *** shared/fsc_pkg.sv ***
// Types shared by the forced-stop controller
`default_nettype none
package fsc_pkg;
   typedef enum logic [1:0] {
      ST_RUN = 2'b00,
      ST_DECEL = 2'b01,
      ST_HALT = 2'b10
   } stop_state_type;
   typedef enum logic [2:0] {
      M_BRAKE = 3'b000,
      M_TQ_HOLD = 3'b001,
      M_TQ_COAST = 3'b010,
      M_RAMP_HOLD = 3'b011,
      M_RAMP_COAST = 3'b100
   } stop_method_type;
   typedef struct packed {
      logic [15:0] speed;
      logic [15:0] max_speed;
      logic [15:0] max_torque;
   } motor_fb_type;
   typedef struct packed {
      logic [15:0] speed_cmd;
      logic [15:0] torque_limit;
      logic decel;
      logic dyn_brake;
      logic coast;
   } drive_cmd_type;
endpackage
`default_nettype wire

// *** src/forced_stop_controller.sv ***
// Forced-stop sequencer with Wishbone register access
//
// The Wishbone slave port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "fsc_map.svh"
module forced_stop_controller #(
   parameter int unsigned CYC_PER_MS = `FSC_MS_PS / `FSC_CLK_PS
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [17:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic forced_stop_in_i,
   input wire logic servo_on_i,
   input wire logic torque_mode_i,
   input wire logic alarm_g2_i,
   input wire logic restart_i,
   input wire fsc_pkg::motor_fb_type motor_fb_i,
   output fsc_pkg::drive_cmd_type drive_o,
   output logic fstop_display_o,
   output logic irq_o
);
   logic fs_meta_q;
   logic fs_sync_q;
   logic ack_q;
   logic [31:0] dat_q;
   logic [15:0] method_reg_q;
   logic [15:0] decel_q;
   logic [15:0] estop_q;
   logic [15:0] ctrl_q;
   logic [2:0] irq_stat_q;
   logic [2:0] irq_en_q;
   fsc_pkg::stop_method_type method_q;
   fsc_pkg::stop_method_type act_q;
   fsc_pkg::stop_state_type state_q;
   logic latch_q;
   logic disp_q;
   logic irq_q;
   logic [31:0] span_q;
   logic [31:0] acc_q;
   fsc_pkg::drive_cmd_type drive_q;
   logic wb_go;
   logic wr_go;
   logic [15:0] idx;
   logic fs_req;
   logic g2_decel;
   logic stop_go;
   logic standstill;
   logic [2:0] irq_evt;
   logic [15:0] tq_lim;
   logic [31:0] acc_sum;
   fsc_pkg::stop_method_type entry_method;

   // Byte-lane merge of a 16-bit register
   function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] d, input logic [3:0] sel);
      logic [15:0] r;
      r = old;
      if (sel[0]) begin
         r[7:0] = d[7:0];
      end
      if (sel[1]) begin
         r[15:8] = d[15:8];
      end
      return r;
   endfunction

   // Drive state to apply once stopped
   function automatic logic post_coast(input fsc_pkg::stop_method_type m, input logic off_coast);
      logic r;
      r = off_coast;
      if (m == fsc_pkg::M_TQ_COAST || m == fsc_pkg::M_RAMP_COAST) begin
         r = 1'b1;
      end
      return r;
   endfunction

   assign wb_go = wb_cyc_i & wb_stb_i & ~ack_q;
   assign wr_go = wb_go & wb_we_i;
   assign idx = wb_adr_i[17:2];

   // Pin passes two flops before use
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         fs_meta_q <= 1'b0;
         fs_sync_q <= 1'b0;
      end else begin
         fs_meta_q <= forced_stop_in_i;
         fs_sync_q <= fs_meta_q;
      end
   end

   assign fs_req = (ctrl_q[`FSC_CTRL_ALLOC_LSB +: 4] != 4'h0) & ~fs_sync_q;
   assign g2_decel = alarm_g2_i & (ctrl_q[`FSC_CTRL_G2_LSB +: 2] == 2'h1 || ctrl_q[`FSC_CTRL_G2_LSB +: 2] == 2'h2);
   assign stop_go = fs_req | alarm_g2_i;
   assign standstill = motor_fb_i.speed == 16'h0000;

   always_comb begin
      entry_method = method_q;
      if (!fs_req) begin
         if (g2_decel) begin
            entry_method = (ctrl_q[`FSC_CTRL_G2_LSB +: 2] == 2'h1) ? fsc_pkg::M_TQ_HOLD : fsc_pkg::M_TQ_COAST;
         end else begin
            entry_method = fsc_pkg::M_BRAKE;
         end
      end
      if (torque_mode_i) begin
         entry_method = fsc_pkg::M_BRAKE;
      end
   end

   assign tq_lim = (estop_q < motor_fb_i.max_torque) ? estop_q : motor_fb_i.max_torque;
   assign acc_sum = acc_q + {16'h0000, motor_fb_i.max_speed};

   // Bus handshake; ack drops the cycle after it is given
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= wb_go;
      end
   end

   // Read mux; unmapped indices read zero
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dat_q <= 32'h0000_0000;
      end else if (wb_go && !wb_we_i) begin
         if (idx == `FSC_IDX_METHOD) begin
            dat_q <= {16'h0000, method_reg_q};
         end else if (idx == `FSC_IDX_DECEL) begin
            dat_q <= {16'h0000, decel_q};
         end else if (idx == `FSC_IDX_ESTOP) begin
            dat_q <= {16'h0000, estop_q};
         end else if (idx == `FSC_IDX_CTRL) begin
            dat_q <= {16'h0000, ctrl_q};
         end else if (idx == `FSC_IDX_STAT) begin
            dat_q <= {24'h00_0000, act_q, state_q, latch_q, disp_q, fs_sync_q};
         end else if (idx == `FSC_IDX_IRQ_STAT) begin
            dat_q <= {29'h0, irq_stat_q};
         end else if (idx == `FSC_IDX_IRQ_EN) begin
            dat_q <= {29'h0, irq_en_q};
         end else begin
            dat_q <= 32'h0000_0000;
         end
      end
   end

   // Setting registers; out-of-range deceleration time and stop torque writes clamp to the limit
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         method_reg_q <= `FSC_METHOD_RST;
         decel_q <= `FSC_DECEL_RST;
         estop_q <= `FSC_ESTOP_RST;
         ctrl_q <= `FSC_CTRL_RST;
         irq_en_q <= 3'h0;
      end else if (wr_go) begin
         if (idx == `FSC_IDX_METHOD) begin
            method_reg_q <= merge(method_reg_q, wb_dat_i, wb_sel_i);
         end else if (idx == `FSC_IDX_DECEL) begin
            if (merge(decel_q, wb_dat_i, wb_sel_i) > `FSC_DECEL_MAX) begin
               decel_q <= `FSC_DECEL_MAX;
            end else begin
               decel_q <= merge(decel_q, wb_dat_i, wb_sel_i);
            end
         end else if (idx == `FSC_IDX_ESTOP) begin
            if (merge(estop_q, wb_dat_i, wb_sel_i) > `FSC_ESTOP_MAX) begin
               estop_q <= `FSC_ESTOP_MAX;
            end else begin
               estop_q <= merge(estop_q, wb_dat_i, wb_sel_i);
            end
         end else if (idx == `FSC_IDX_CTRL) begin
            ctrl_q <= merge(ctrl_q, wb_dat_i, wb_sel_i);
         end else if (idx == `FSC_IDX_IRQ_EN && wb_sel_i[0]) begin
            irq_en_q <= wb_dat_i[2:0];
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         method_q <= fsc_pkg::M_TQ_HOLD;
      end else if (restart_i) begin
         // Illegal codes fall back to the default method
         if (method_reg_q[`FSC_METHOD_LSB +: 3] <= `FSC_METHOD_MAX) begin
            method_q <= fsc_pkg::stop_method_type'(method_reg_q[`FSC_METHOD_LSB +: 3]);
         end else begin
            method_q <= fsc_pkg::M_TQ_HOLD;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         latch_q <= 1'b0;
      end else if (fs_req && servo_on_i) begin
         latch_q <= 1'b1;
      end else if (!servo_on_i && !fs_req) begin
         latch_q <= 1'b0;
      end
   end

   // Stop sequencer
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_q <= fsc_pkg::ST_RUN;
         act_q <= fsc_pkg::M_BRAKE;
      end else begin
         case (state_q)
            fsc_pkg::ST_RUN: begin
               if (stop_go) begin
                  act_q <= entry_method;
                  if (entry_method == fsc_pkg::M_BRAKE) begin
                     state_q <= fsc_pkg::ST_HALT;
                  end else begin
                     state_q <= fsc_pkg::ST_DECEL;
                  end
               end
            end
            fsc_pkg::ST_DECEL: begin
               // Torque mode mid-ramp ends the ramp and goes straight to halt
               if (standstill || torque_mode_i) begin
                  state_q <= fsc_pkg::ST_HALT;
               end
            end
            fsc_pkg::ST_HALT: begin
               if (!stop_go && !latch_q) begin
                  state_q <= fsc_pkg::ST_RUN;
               end
            end
            default: begin
               state_q <= fsc_pkg::ST_RUN;
            end
         endcase
      end
   end

   // ramp span is the set time in clock cycles
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         span_q <= 32'h0000_0000;
      end else begin
         span_q <= 32'(decel_q * CYC_PER_MS);
      end
   end

   // Speed command and torque limit
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         drive_q <= '0;
         acc_q <= 32'h0000_0000;
      end else begin
         drive_q.decel <= 1'b0;
         drive_q.dyn_brake <= 1'b0;
         drive_q.coast <= 1'b0;
         drive_q.torque_limit <= motor_fb_i.max_torque;
         case (state_q)
            fsc_pkg::ST_RUN: begin
               drive_q.speed_cmd <= motor_fb_i.speed;
               acc_q <= 32'h0000_0000;
            end
            fsc_pkg::ST_DECEL: begin
               drive_q.decel <= 1'b1;
               if (act_q == fsc_pkg::M_TQ_HOLD || act_q == fsc_pkg::M_TQ_COAST) begin
                  drive_q.torque_limit <= tq_lim;
                  drive_q.speed_cmd <= 16'h0000;
               end else if (span_q == 32'h0000_0000) begin
                  drive_q.speed_cmd <= 16'h0000;
               end else if (acc_sum >= span_q) begin
                  acc_q <= acc_sum - span_q;
                  if (drive_q.speed_cmd != 16'h0000) begin
                     drive_q.speed_cmd <= drive_q.speed_cmd - 16'h0001;
                  end
               end else begin
                  acc_q <= acc_sum;
               end
            end
            fsc_pkg::ST_HALT: begin
               drive_q.speed_cmd <= 16'h0000;
               if (post_coast(act_q, ctrl_q[`FSC_CTRL_COAST_BIT])) begin
                  drive_q.coast <= 1'b1;
               end else begin
                  drive_q.dyn_brake <= 1'b1;
               end
            end
            default: begin
               drive_q.speed_cmd <= 16'h0000;
            end
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         disp_q <= 1'b0;
      end else begin
         disp_q <= fs_req | latch_q;
      end
   end

   // Events: stop entered, ramp ended (standstill or torque mode), stop released
   assign irq_evt[0] = (state_q == fsc_pkg::ST_RUN) & stop_go;
   assign irq_evt[1] = (state_q == fsc_pkg::ST_DECEL) & (standstill | torque_mode_i);
   assign irq_evt[2] = (state_q == fsc_pkg::ST_HALT) & ~stop_go & ~latch_q;

   // Sticky status; a new event wins over a clear
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_stat_q <= 3'h0;
      end else if (wr_go && idx == `FSC_IDX_IRQ_CLR && wb_sel_i[0]) begin
         irq_stat_q <= (irq_stat_q & ~wb_dat_i[2:0]) | irq_evt;
      end else begin
         irq_stat_q <= irq_stat_q | irq_evt;
      end
   end
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= |(irq_stat_q & irq_en_q);
      end
   end

   assign wb_ack_o = ack_q;
   assign wb_dat_o = dat_q;
   assign drive_o = drive_q;
   assign fstop_display_o = disp_q;
   assign irq_o = irq_q;
endmodule
`default_nettype wire

// *** dv/fsc_switch_motor.sv ***
// Stop switch and motor plant on the far side of the controller
`timescale 1ns/1ps
`default_nettype none
module fsc_switch_motor #(
   parameter int MAXS = 8,
   parameter logic [15:0] MAXT = 16'h0064
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic closed_i,
   input wire fsc_pkg::drive_cmd_type drive_i,
   output logic forced_stop_in_o,
   output fsc_pkg::motor_fb_type motor_fb_o
);
   logic [15:0] speed_q;
   assign forced_stop_in_o = closed_i;
   // Motor follows the command only while decelerating; braked or coasting it stays put
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         speed_q <= 16'(MAXS);
      end else if (drive_i.decel) begin
         speed_q <= drive_i.speed_cmd;
      end else if (!drive_i.dyn_brake && !drive_i.coast) begin
         speed_q <= 16'(MAXS);
      end
   end
   assign motor_fb_o = '{speed: speed_q, max_speed: 16'(MAXS), max_torque: MAXT};
endmodule
`default_nettype wire

// *** dv/fsc_asserts.sv ***
// Port-level checks of the forced-stop controller
`timescale 1ns/1ps
`default_nettype none
module fsc_asserts #(
   parameter int unsigned CYC_PER_MS = 200000
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_ack_o,
   input wire logic forced_stop_in_i,
   input wire logic servo_on_i,
   input wire logic torque_mode_i,
   input wire fsc_pkg::motor_fb_type motor_fb_i,
   input wire fsc_pkg::drive_cmd_type drive_o,
   input wire logic fstop_display_o,
   input wire logic irq_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("request not acked next cycle");
   reset_quiet_a: assert property (disable iff (1'b0) rst_i |=> !wb_ack_o && !irq_o && !fstop_display_o && drive_o == '0)
      else $error("outputs active after reset edge");
   torque_no_decel_a: assert property ($rose(drive_o.decel) |-> !$past(torque_mode_i, 2))
      else $error("decel started in torque control");
   torque_cap_a: assert property (drive_o.decel |-> drive_o.torque_limit <= motor_fb_i.max_torque)
      else $error("stop torque above motor maximum");
   brake_alone_a: assert property (drive_o.dyn_brake |-> !drive_o.coast && !drive_o.decel)
      else $error("brake mixed with coast or decel");
   display_cause_a: assert property ($rose(fstop_display_o) |->
      !$past(forced_stop_in_i, 2) || !$past(forced_stop_in_i, 3) || !$past(forced_stop_in_i, 4))
      else $error("display rose without open input");
   latch_hold_a: assert property (fstop_display_o && servo_on_i && $past(servo_on_i) |=> fstop_display_o)
      else $error("stop dropped while servo on");
   stop_at_rest_a: assert property (drive_o.decel && motor_fb_i.speed == 16'h0000 |->
      ##2 !drive_o.decel && (drive_o.dyn_brake || drive_o.coast))
      else $error("no halt after standstill");
endmodule
bind forced_stop_controller fsc_asserts #(.CYC_PER_MS(CYC_PER_MS)) fsc_asserts_inst (.clk_i(clk_i), .rst_i(rst_i),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .forced_stop_in_i(forced_stop_in_i),
   .servo_on_i(servo_on_i), .torque_mode_i(torque_mode_i), .motor_fb_i(motor_fb_i), .drive_o(drive_o),
   .fstop_display_o(fstop_display_o), .irq_o(irq_o));
`default_nettype wire

// *** dv/forced_stop_controller_tb_top.sv ***
// Self-checking bench for the forced-stop controller
`timescale 1ns/1ps
`default_nettype none
`include "fsc_map.svh"
module forced_stop_controller_tb_top;
   localparam int MAXS = 8;
   localparam logic [15:0] MAXT = 16'h0064;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, disp, irq, fs_pin, sdec;
   logic closed = 1'b1, son = 1'b0, tqm = 1'b0, alarm = 1'b0, restart = 1'b0;
   logic [17:0] adr = '0;
   logic [3:0] sel = 4'h3;
   logic [31:0] wdat = '0, rdat, wb_q;
   logic [15:0] tl, sp0;
   fsc_pkg::motor_fb_type fb;
   fsc_pkg::drive_cmd_type drv;
   int n_errors = 0, comparisons = 0, cycles = 0, ndec;
   forced_stop_controller #(.CYC_PER_MS(10)) forced_stop_controller_inst (.clk_i(clk_i), .rst_i(rst_i),
      .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
      .wb_dat_o(wb_q), .wb_ack_o(ack), .forced_stop_in_i(fs_pin), .servo_on_i(son), .torque_mode_i(tqm),
      .alarm_g2_i(alarm), .restart_i(restart), .motor_fb_i(fb), .drive_o(drv), .fstop_display_o(disp),
      .irq_o(irq));
   fsc_switch_motor #(.MAXS(MAXS), .MAXT(MAXT)) fsc_switch_motor_inst (.clk_i(clk_i), .rst_i(rst_i),
      .closed_i(closed), .drive_i(drv), .forced_stop_in_o(fs_pin), .motor_fb_o(fb));
   initial begin
      forever #2.5 clk_i = ~clk_i;
   end
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 10000) begin
         n_errors++;
         tally_and_finish();
      end
      if (drv.decel === 1'b1) begin
         if (!sdec) sp0 = drv.speed_cmd;
         sdec = 1'b1;
         tl = drv.torque_limit;
         ndec++;
      end
   end
   task tally_and_finish;
      $display("comparisons %0d mismatches %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      comparisons++;
      if (seen !== exp) begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task wb(input logic w, input logic [15:0] idx, input logic [15:0] d);
      int n;
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= {idx, 2'b00};
      wdat <= {16'h0000, d};
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack !== 1'b1 && n < 50);
      rdat = wb_q;
      cyc <= 1'b0;
      stb <= 1'b0;
      check(ack, 1'b1, "wb ack");
   endtask
   task rd(input logic [15:0] idx, input logic [15:0] exp, input string what);
      wb(1'b0, idx, 16'h0000);
      check(rdat, {16'h0000, exp}, what);
   endtask
   task halt(input logic pin, input logic al);
      int n;
      sdec = 1'b0;
      ndec = 0;
      @(posedge clk_i);
      closed <= pin;
      alarm <= al;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (!(drv.dyn_brake === 1'b1 || drv.coast === 1'b1) && n < 200);
   endtask
   task release_all;
      @(posedge clk_i);
      closed <= 1'b1;
      alarm <= 1'b0;
      tqm <= 1'b0;
      repeat (8) @(posedge clk_i);
   endtask
   task t_regs;
      rd(`FSC_IDX_METHOD, 16'h0010, "method reset");
      rd(`FSC_IDX_DECEL, 16'h0000, "decel reset");
      rd(`FSC_IDX_ESTOP, 16'h0320, "estop reset");
      rd(`FSC_IDX_IRQ_EN, 16'h0000, "irq enable reset");
      wb(1'b1, 16'h0001, 16'h1234);
      rd(16'h0001, 16'h0000, "unmapped");
      wb(1'b1, `FSC_IDX_ESTOP, 16'h0400);
      rd(`FSC_IDX_ESTOP, 16'h0320, "estop clamp");
      wb(1'b1, `FSC_IDX_DECEL, 16'h3000);
      rd(`FSC_IDX_DECEL, 16'h2710, "decel clamp");
      wb(1'b1, `FSC_IDX_DECEL, 16'h0000);
      halt(1'b0, 1'b0);
      check({disp, drv.dyn_brake, drv.coast}, 3'b000, "unallocated");
      release_all();
      $display("test regs done");
   endtask
   task t_methods;
      wb(1'b1, `FSC_IDX_CTRL, 16'h0001);
      for (int m = 0; m < 5; m++) begin
         wb(1'b1, `FSC_IDX_METHOD, {9'h000, m[2:0], 4'h0});
         wb(1'b1, `FSC_IDX_ESTOP, (m == 2) ? 16'h0320 : 16'h0032);
         @(posedge clk_i);
         restart <= 1'b1;
         @(posedge clk_i);
         restart <= 1'b0;
         halt(1'b0, 1'b0);
         check(sdec, m != 0, "decel used");
         check({drv.dyn_brake, drv.coast}, (m == 2 || m == 4) ? 2'b01 : 2'b10, "after stop");
         if (m > 0) check(sp0, 16'h0000, "stop speed");
         if (m == 1 || m == 2) check(tl, (m == 1) ? 16'h0032 : MAXT, "stop torque");
         check({disp, irq}, 2'b10, "display masked irq");
         // Status shows the method taken at stop entry
         wb(1'b0, `FSC_IDX_STAT, 16'h0000);
         check(rdat[7:5], m[2:0], "active method");
         wb(1'b0, `FSC_IDX_IRQ_STAT, 16'h0000);
         check(rdat[0], 1'b1, "stop event");
         wb(1'b1, `FSC_IDX_IRQ_CLR, 16'h0007);
         release_all();
         check({disp, drv.dyn_brake, drv.coast}, 3'b000, "released");
      end
      wb(1'b1, `FSC_IDX_METHOD, 16'h0000);
      halt(1'b0, 1'b0);
      wb(1'b0, `FSC_IDX_STAT, 16'h0000);
      check(rdat[7:5], 3'h4, "method without restart");
      release_all();
      $display("test methods done");
   endtask
   task t_modes;
      wb(1'b1, `FSC_IDX_CTRL, 16'h0011);
      @(posedge clk_i);
      tqm <= 1'b1;
      halt(1'b0, 1'b0);
      check({sdec, drv.dyn_brake, drv.coast}, 3'b001, "torque mode stop");
      release_all();
      wb(1'b1, `FSC_IDX_CTRL, 16'h0021);
      halt(1'b1, 1'b1);
      check({sdec, tl}, {1'b1, 16'h0032}, "alarm decel");
      release_all();
      wb(1'b1, `FSC_IDX_CTRL, 16'h0041);
      halt(1'b1, 1'b1);
      check({sdec, drv.dyn_brake, drv.coast}, 3'b101, "alarm coast");
      release_all();
      wb(1'b1, `FSC_IDX_CTRL, 16'h0001);
      wb(1'b1, `FSC_IDX_DECEL, 16'h0002);
      halt(1'b0, 1'b0);
      check(ndec >= 18 && ndec <= 24, 1'b1, "ramp length");
      check(drv.coast, 1'b1, "ramp coast");
      release_all();
      $display("test modes done");
   endtask
   task t_latch;
      // Earlier stops left sticky bits behind
      wb(1'b1, `FSC_IDX_IRQ_CLR, 16'h0007);
      wb(1'b1, `FSC_IDX_IRQ_EN, 16'h0001);
      check(irq, 1'b0, "irq idle");
      @(posedge clk_i);
      son <= 1'b1;
      halt(1'b0, 1'b0);
      check(irq, 1'b1, "irq raised");
      @(posedge clk_i);
      closed <= 1'b1;
      repeat (8) @(posedge clk_i);
      check(disp, 1'b1, "latched");
      wb(1'b1, `FSC_IDX_IRQ_CLR, 16'h0001);
      repeat (2) @(posedge clk_i);
      check(irq, 1'b0, "irq cleared");
      @(posedge clk_i);
      son <= 1'b0;
      repeat (4) @(posedge clk_i);
      son <= 1'b1;
      repeat (4) @(posedge clk_i);
      check({disp, drv.dyn_brake, drv.coast}, 3'b000, "unlatched");
      $display("test latch done");
   endtask
   initial begin
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      t_regs();
      t_methods();
      t_modes();
      t_latch();
      tally_and_finish();
   end
endmodule
`default_nettype wire
